// file: bridge_header_bus_io_window_regs.sv
// bridge header bus number and i/o window registers behind apb
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module bridge_header_bus_io_window_regs
  import bridge_regs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // lock for the width bit, from switch core
  input wire logic io_width_lock,
  // i/o request to be checked against the window
  input wire logic io_req_valid,
  input wire logic [31:0] io_req_addr,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  output logic io_fwd_valid,
  output logic io_fwd_hit,
  // stored values for the rest of the switch
  output logic [7:0] primary_bus_number,
  output logic [7:0] secondary_bus_number,
  output logic [7:0] subordinate_bus_number,
  output logic io_addressing_width,
  output logic [3:0] io_window_base,
  output logic [3:0] io_window_limit
);

  // register state
  logic [7:0] pri_bus_reg;
  logic [7:0] pri_bus_next;
  logic [7:0] sec_bus_reg;
  logic [7:0] sec_bus_next;
  logic [7:0] sub_bus_reg;
  logic [7:0] sub_bus_next;
  logic io_width_reg;
  logic io_width_next;
  logic [3:0] io_base_reg;
  logic [3:0] io_base_next;
  logic [3:0] io_limit_reg;
  logic [3:0] io_limit_next;

  // apb response state
  apb_phase_t phase_reg;
  apb_phase_t phase_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;

  // forwarding state
  logic fwd_valid_reg;
  logic fwd_valid_next;
  logic fwd_hit_reg;
  logic fwd_hit_next;

  // decode helpers
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic mapped;
  logic access;
  logic wr_commit;
  logic lane0;
  logic [7:0] wbyte;
  logic [7:0] io_base_byte;
  logic [7:0] io_limit_byte;
  logic [DATA_W-1:0] rd_mux;

  // per-field write strobes
  logic wr_pri_bus;
  logic wr_sec_bus;
  logic wr_sub_bus;
  logic wr_io_base;
  logic wr_io_limit;
  logic wr_width;

  // window bounds
  logic [31:0] win_lo;
  logic [31:0] win_hi;
  logic win_hit;

  // word index and alignment of the current request
  assign idx = IDX_W'(paddr[ADDR_W-1:2]);
  assign aligned = (paddr[1:0] == ALIGN_OK);
  assign access = psel && penable;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  // a write lands only at the edge that completes the transfer
  assign wr_commit = (phase_reg == ph_answer) && access && pwrite &&
                     !pslverr_reg;

  assign io_base_byte = {io_base_reg, IO_RSVD, io_width_reg};
  assign io_limit_byte = {io_limit_reg, IO_RSVD, io_width_reg};

  // address map check
  always_comb begin
    mapped = 1'b0;
    case (idx)
      IDX_PRI_LAT,
      IDX_HDR_TYPE,
      IDX_SELF_TEST,
      IDX_BASE_ADDR0,
      IDX_BASE_ADDR1,
      IDX_PRI_BUS,
      IDX_SEC_BUS,
      IDX_SUB_BUS,
      IDX_SEC_LAT,
      IDX_IO_BASE,
      IDX_IO_LIMIT: begin
        mapped = aligned;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data, narrow fields sit in the low byte
  always_comb begin
    rd_mux = ZERO_WORD;
    case (idx)
      IDX_PRI_LAT: begin
        rd_mux = DATA_W'(ZERO_BYTE);
      end
      IDX_HDR_TYPE: begin
        rd_mux = DATA_W'(HEADER_TYPE_VAL);
      end
      IDX_SELF_TEST: begin
        rd_mux = DATA_W'(ZERO_BYTE);
      end
      IDX_BASE_ADDR0,
      IDX_BASE_ADDR1: begin
        rd_mux = ZERO_WORD;
      end
      IDX_PRI_BUS: begin
        rd_mux = DATA_W'(pri_bus_reg);
      end
      IDX_SEC_BUS: begin
        rd_mux = DATA_W'(sec_bus_reg);
      end
      IDX_SUB_BUS: begin
        rd_mux = DATA_W'(sub_bus_reg);
      end
      IDX_SEC_LAT: begin
        rd_mux = DATA_W'(ZERO_BYTE);
      end
      IDX_IO_BASE: begin
        rd_mux = DATA_W'(io_base_byte);
      end
      IDX_IO_LIMIT: begin
        rd_mux = DATA_W'(io_limit_byte);
      end
      default: begin
        rd_mux = ZERO_WORD;
      end
    endcase
    // misaligned or unmapped reads give zero
    if (!mapped) begin
      rd_mux = ZERO_WORD;
    end
  end

  // apb answer: one wait state, then pready for a single cycle
  always_comb begin
    phase_next = phase_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (phase_reg)
      ph_idle: begin
        if (access) begin
          phase_next = ph_answer;
          pready_next = 1'b1;
          pslverr_next = !mapped;
          prdata_next = pwrite ? ZERO_WORD : rd_mux;
        end
      end
      ph_answer: begin
        // transfer completes here, back to idle
        phase_next = ph_idle;
      end
      default: begin
        phase_next = ph_idle;
      end
    endcase
  end

  // apb answer registers, so outputs come straight from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= ph_idle;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= ZERO_WORD;
    end else begin
      phase_reg <= phase_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // one strobe per writable byte; read-only offsets raise none
  always_comb begin
    wr_pri_bus = 1'b0;
    wr_sec_bus = 1'b0;
    wr_sub_bus = 1'b0;
    wr_io_base = 1'b0;
    wr_io_limit = 1'b0;
    if (wr_commit && lane0) begin
      case (idx)
        IDX_PRI_BUS: begin
          wr_pri_bus = 1'b1;
        end
        IDX_SEC_BUS: begin
          wr_sec_bus = 1'b1;
        end
        IDX_SUB_BUS: begin
          wr_sub_bus = 1'b1;
        end
        IDX_IO_BASE: begin
          wr_io_base = 1'b1;
        end
        IDX_IO_LIMIT: begin
          wr_io_limit = 1'b1;
        end
        default: begin
          wr_pri_bus = 1'b0;
        end
      endcase
    end
  end

  assign wr_width = wr_io_base && !io_width_lock;

  // writable fields keep their value unless their strobe is up
  always_comb begin
    pri_bus_next = pri_bus_reg;
    sec_bus_next = sec_bus_reg;
    sub_bus_next = sub_bus_reg;
    io_width_next = io_width_reg;
    io_base_next = io_base_reg;
    io_limit_next = io_limit_reg;
    if (wr_pri_bus) begin
      pri_bus_next = wbyte;
    end
    if (wr_sec_bus) begin
      sec_bus_next = wbyte;
    end
    if (wr_sub_bus) begin
      sub_bus_next = wbyte;
    end
    if (wr_width) begin
      io_width_next = wbyte[IO_WIDTH_BIT];
    end
    if (wr_io_base) begin
      io_base_next = wbyte[IO_FIELD_MSB:IO_FIELD_LSB];
    end
    if (wr_io_limit) begin
      io_limit_next = wbyte[IO_FIELD_MSB:IO_FIELD_LSB];
    end
  end

  // field registers, reset values match the fresh header
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_bus_reg <= BUS_NUM_RST;
      sec_bus_reg <= BUS_NUM_RST;
      sub_bus_reg <= BUS_NUM_RST;
      io_width_reg <= IO_WIDTH_RST;
      io_base_reg <= IO_BASE_RST;
      io_limit_reg <= IO_LIMIT_RST;
    end else begin
      pri_bus_reg <= pri_bus_next;
      sec_bus_reg <= sec_bus_next;
      sub_bus_reg <= sub_bus_next;
      io_width_reg <= io_width_next;
      io_base_reg <= io_base_next;
      io_limit_reg <= io_limit_next;
    end
  end

  // window from base and limit
  // in 16-bit mode the upper half of the window is forced to zero,
  // so any address with bits 31:16 set misses
  always_comb begin
    if (io_width_reg) begin
      win_lo = {io_base_upper, io_base_reg, IO_LOW_ZERO};
      win_hi = {io_limit_upper, io_limit_reg, IO_LOW_ONES};
    end else begin
      win_lo = {IO_HI_ZERO, io_base_reg, IO_LOW_ZERO};
      win_hi = {IO_HI_ZERO, io_limit_reg, IO_LOW_ONES};
    end
  end

  // inclusive bounds check
  // base above limit leaves the window empty, nothing forwards
  assign win_hit = (io_req_addr >= win_lo) && (io_req_addr <= win_hi);

  // forwarding verdict, one cycle after the request
  always_comb begin
    fwd_valid_next = io_req_valid;
    fwd_hit_next = io_req_valid && win_hit;
  end

  // verdict registers, one cycle of latency for timing margin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid_reg <= 1'b0;
      fwd_hit_reg <= 1'b0;
    end else begin
      fwd_valid_reg <= fwd_valid_next;
      fwd_hit_reg <= fwd_hit_next;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign io_fwd_valid = fwd_valid_reg;
  assign io_fwd_hit = fwd_hit_reg;
  assign primary_bus_number = pri_bus_reg;
  assign secondary_bus_number = sec_bus_reg;
  assign subordinate_bus_number = sub_bus_reg;
  assign io_addressing_width = io_width_reg;
  assign io_window_base = io_base_reg;
  assign io_window_limit = io_limit_reg;

endmodule

// file: bridge_regs_pkg.sv
// constants for the bridge header bus and i/o window registers
// Operation
// - primary latency timer reads as zero, writes ignored
// - header type reads as one, a type 1 single function header
// - self-test byte reads as zero, no self test offered
// - both base address registers read as zero, writes ignored
// - primary bus number is 8-bit read/write, resets to zero
// - secondary bus number is 8-bit read/write, resets to zero
// - subordinate bus number is 8-bit read/write, resets to zero
// - secondary latency timer reads as zero, writes ignored
// - i/o base bit 0 is lockable width bit, one means 32-bit
// - i/o limit bit 0 always mirrors the width bit
// - i/o base bits 7:4 read/write, reset 0xF, address bits 15:12
// - i/o limit bits 7:4 read/write, reset zero, low bits all ones
// - base and limit together steer i/o forwarding
// - bits 3:1 of base and limit read zero, writes ignored
package bridge_regs_pkg;

  // bus geometry
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  // register indexes, byte address is four times these
  localparam logic [9:0] IDX_PRI_LAT = 10'h00D;
  localparam logic [9:0] IDX_HDR_TYPE = 10'h00E;
  localparam logic [9:0] IDX_SELF_TEST = 10'h00F;
  localparam logic [9:0] IDX_BASE_ADDR0 = 10'h010;
  localparam logic [9:0] IDX_BASE_ADDR1 = 10'h014;
  localparam logic [9:0] IDX_PRI_BUS = 10'h018;
  localparam logic [9:0] IDX_SEC_BUS = 10'h019;
  localparam logic [9:0] IDX_SUB_BUS = 10'h01A;
  localparam logic [9:0] IDX_SEC_LAT = 10'h01B;
  localparam logic [9:0] IDX_IO_BASE = 10'h01C;
  localparam logic [9:0] IDX_IO_LIMIT = 10'h01D;

  // field positions inside the i/o base and limit bytes
  localparam int IO_WIDTH_BIT = 0;
  localparam int IO_FIELD_LSB = 4;
  localparam int IO_FIELD_MSB = 7;

  // fixed and reset values
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] HEADER_TYPE_VAL = 8'h01;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] BUS_NUM_RST = 8'h00;
  localparam logic IO_WIDTH_RST = 1'h1;
  localparam logic [3:0] IO_BASE_RST = 4'hF;
  localparam logic [3:0] IO_LIMIT_RST = 4'h0;
  localparam logic [2:0] IO_RSVD = 3'h0;

  // i/o window granularity fill
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
  localparam logic [15:0] IO_HI_ZERO = 16'h0000;

  // apb response phase
  typedef enum logic {
    ph_idle,
    ph_answer
  } apb_phase_t;

endpackage

// file: bridge_regs_properties.sv
// port-level checks for the bridge header register block
`timescale 1ns/1ps
module bridge_regs_properties #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic io_width_lock,
  input wire logic io_req_valid,
  input wire logic [31:0] io_req_addr,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire logic io_fwd_valid,
  input wire logic io_fwd_hit,
  input wire logic [7:0] primary_bus_number,
  input wire logic io_addressing_width,
  input wire logic [3:0] io_window_base,
  input wire logic [3:0] io_window_limit
);
  logic [15:0] ub;
  logic [15:0] ul;
  logic hit;
  logic rd_ok;
  // window bounds, upper half only counts in 32-bit mode
  assign ub = io_addressing_width ? io_base_upper : 16'h0000;
  assign ul = io_addressing_width ? io_limit_upper : 16'h0000;
  assign hit = io_req_addr >= {ub, io_window_base, 12'h000} &&
    io_req_addr <= {ul, io_window_limit, 12'hFFF};
  assign rd_ok = psel && penable && pready && !pwrite && !pslverr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a good write to the primary bus number, then its effect
  sequence s_pri_wr;
    psel && penable && pready && pwrite && !pslverr && pstrb[0] &&
      paddr == 12'h060;
  endsequence
  sequence s_pri_new;
    primary_bus_number == $past(pwdata[7:0]);
  endsequence
  a_hdr_one: assert property (rd_ok && paddr == 12'h038 |->
    prdata == 32'h0000_0001) else $error("header type not one");
  a_ro_zero: assert property (rd_ok && paddr inside {12'h034, 12'h03C,
    12'h040, 12'h050, 12'h06C} |-> prdata == 32'h0)
    else $error("fixed field not zero");
  a_base_fields: assert property (rd_ok && paddr == 12'h070 |->
    prdata == {24'h0, io_window_base, 3'h0, io_addressing_width})
    else $error("io base read wrong");
  a_limit_mirror: assert property (rd_ok && paddr == 12'h074 |->
    prdata == {24'h0, io_window_limit, 3'h0, io_addressing_width})
    else $error("io limit read wrong");
  a_pri_write: assert property (s_pri_wr |=> s_pri_new)
    else $error("primary bus write lost");
  a_lock_holds: assert property (io_width_lock |=>
    $stable(io_addressing_width)) else $error("locked width bit moved");
  a_fwd_window: assert property (io_req_valid |=> io_fwd_valid &&
    io_fwd_hit == $past(hit)) else $error("forward decision wrong");
  a_fwd_only: assert property (io_fwd_valid |-> $past(io_req_valid))
    else $error("forward without request");
endmodule

bind bridge_header_bus_io_window_regs bridge_regs_properties #(
  .ADDR_W(ADDR_W)
) chk (.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .io_width_lock, .io_req_valid, .io_req_addr,
  .io_base_upper, .io_limit_upper, .io_fwd_valid, .io_fwd_hit,
  .primary_bus_number, .io_addressing_width, .io_window_base,
  .io_window_limit);

// file: apb_host_model.sv
// apb host issuing configuration accesses
`timescale 1ns/1ps
module apb_host_model (
  input wire logic clk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // one transfer; waits on pready, the bench watchdog bounds it
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    // released lines flip so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= ~s;
  endtask
endmodule

// file: bridge_header_bus_io_window_regs_bench.sv
// self-checking bench for the bridge header register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h seen %h", n, e, g); end end
module bridge_header_bus_io_window_regs_bench;
  import bridge_regs_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, io_req_addr;
  logic [3:0] pstrb, io_window_base, io_window_limit;
  logic io_width_lock, io_req_valid, io_fwd_valid, io_fwd_hit;
  logic io_addressing_width;
  logic [15:0] io_base_upper, io_limit_upper;
  logic [7:0] primary_bus_number, secondary_bus_number;
  logic [7:0] subordinate_bus_number;
  int err_count, checked;
  logic [9:0] ro_idx [6] = '{IDX_PRI_LAT, IDX_HDR_TYPE, IDX_SELF_TEST,
    IDX_BASE_ADDR0, IDX_BASE_ADDR1, IDX_SEC_LAT};
  logic [31:0] ro_val [6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

  apb_host_model host (.clk, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  bridge_header_bus_io_window_regs uut (.clk, .reset_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .io_width_lock, .io_req_valid, .io_req_addr, .io_base_upper,
    .io_limit_upper, .io_fwd_valid, .io_fwd_hit, .primary_bus_number,
    .secondary_bus_number, .subordinate_bus_number, .io_addressing_width,
    .io_window_base, .io_window_limit);

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  task automatic wr(input logic [9:0] i, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, ba(i), d, s, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input logic xe, input string n);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, 4'h0, q, e);
    `CHK(n, x, q)
    `CHK(n, xe, e)
  endtask
  task automatic fwd(input logic [31:0] a, input logic x);
    @(posedge clk);
    io_req_valid <= 1'b1;
    io_req_addr <= a;
    @(posedge clk);
    io_req_valid <= 1'b0;
    #1;
    `CHK("fwd valid", 1'b1, io_fwd_valid)
    `CHK("fwd hit", x, io_fwd_hit)
  endtask

  task automatic t_reset();
    for (int k = 0; k < 6; k++) begin
      rd(ba(ro_idx[k]), ro_val[k], 1'b0, "ro");
    end
    for (int k = 0; k < 3; k++) begin
      rd(ba(IDX_PRI_BUS + 10'(k)), 32'h0, 1'b0, "bus rst");
    end
    rd(ba(IDX_IO_BASE), 32'hF1, 1'b0, "io base rst");
    rd(ba(IDX_IO_LIMIT), 32'h01, 1'b0, "io limit rst");
  endtask
  // every fixed field keeps its value after an all-ones write
  task automatic t_ro();
    for (int k = 0; k < 6; k++) wr(ro_idx[k], 32'hFFFF_FFFF, 4'hF);
    for (int k = 0; k < 6; k++) begin
      rd(ba(ro_idx[k]), ro_val[k], 1'b0, "ro wr");
    end
    rd(12'h044, 32'h0, 1'b1, "unmapped");
    rd(ba(IDX_HDR_TYPE) + 12'h1, 32'h0, 1'b1, "misaligned");
  endtask
  task automatic t_bus();
    wr(IDX_PRI_BUS, 32'hA5, 4'h1);
    wr(IDX_SEC_BUS, 32'h5A, 4'h1);
    wr(IDX_SUB_BUS, 32'hFF, 4'h1);
    wr(IDX_PRI_BUS, 32'h00, 4'h0);
    rd(ba(IDX_PRI_BUS), 32'hA5, 1'b0, "pri bus");
    rd(ba(IDX_SEC_BUS), 32'h5A, 1'b0, "sec bus");
    rd(ba(IDX_SUB_BUS), 32'hFF, 1'b0, "sub bus");
    `CHK("pri port", 8'hA5, primary_bus_number)
    `CHK("sec port", 8'h5A, secondary_bus_number)
    `CHK("sub port", 8'hFF, subordinate_bus_number)
  endtask
  // 16-bit mode, window 0x2000..0x3FFF, then lock the width bit
  task automatic t_io();
    wr(IDX_IO_BASE, 32'h2E, 4'h1);
    wr(IDX_IO_LIMIT, 32'h3F, 4'h1);
    rd(ba(IDX_IO_BASE), 32'h20, 1'b0, "io base");
    rd(ba(IDX_IO_LIMIT), 32'h30, 1'b0, "io limit");
    io_width_lock <= 1'b1;
    wr(IDX_IO_BASE, 32'h21, 4'h1);
    rd(ba(IDX_IO_LIMIT), 32'h30, 1'b0, "locked");
    `CHK("width port", 1'b0, io_addressing_width)
    `CHK("base port", 4'h2, io_window_base)
    `CHK("limit port", 4'h3, io_window_limit)
  endtask
  task automatic t_fwd();
    fwd(32'h0000_1FFF, 1'b0);
    fwd(32'h0000_2000, 1'b1);
    fwd(32'h0000_3FFF, 1'b1);
    fwd(32'h0000_4000, 1'b0);
    fwd(32'h0001_2000, 1'b0);
    io_width_lock <= 1'b0;
    wr(IDX_IO_BASE, 32'h21, 4'h1);
    fwd(32'h0001_2000, 1'b1);
    fwd(32'h0000_2000, 1'b0);
    wr(IDX_IO_LIMIT, 32'h10, 4'h1);
    fwd(32'h0001_2000, 1'b0);
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // reset for five cycles, then the scenarios in turn
  initial begin
    {reset_n, io_width_lock, io_req_valid} = 3'h0;
    io_req_addr = 32'h0;
    io_base_upper = 16'h0001;
    io_limit_upper = 16'h0001;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ro();
    t_bus();
    t_io();
    t_fwd();
    finish_test();
  end
  // hang guard, far beyond the roughly 185 cycles needed
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule
